// >>> logic/dsr_pkg.sv
// Constants, field layouts and carrier types for the DIMM sparing, mirroring and error-rate block.
// Assumes a 50 MHz controller clock and a 32-bit AXI4-Lite register port.
package dsr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_SPARING_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DED_THRESHOLD   = 8'h04;
  localparam logic [7:0] OFF_SEC_THRESHOLDS  = 8'h08;
  localparam logic [7:0] OFF_THR_FLAGS       = 8'h0C;
  localparam logic [7:0] OFF_STATUS          = 8'h10;

  // sparing_control field positions
  localparam int CTL_SPARE_EN  = 0;
  localparam int CTL_MIRROR_EN = 1;
  localparam int CTL_PERIOD_LO = 2;
  localparam int CTL_ESC_LO    = 5;
  localparam int CTL_MIR_POL   = 7;
  localparam int CTL_VICTIM_LO = 8;
  localparam int CTL_START     = 11;

  // Reset values
  localparam logic [11:0] CTL_RESET = 12'h000;
  localparam logic [7:0]  THR_RESET = 8'h00;

  // Escalation codes
  localparam logic [1:0] ESC_POLL = 2'h0;
  localparam logic [1:0] ESC_INT  = 2'h1;
  localparam logic [1:0] ESC_SMI  = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: leak unit of 1 us at the controller clock rate
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned LEAK_UNIT_NS = 1000;
  localparam int unsigned UNIT_CYCLES  = LEAK_UNIT_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [5:0]  UNIT_LAST    = 6'(UNIT_CYCLES - 1);
  localparam int          PERIOD_SHIFT = 4;

  // Geometry
  localparam int NUM_DIMMS = 8;
  localparam int MIRROR_ADDR_BIT = 15;

  // Sparing sequence, Gray coded along idle -> copy -> done
  typedef enum logic [1:0] {
    DSR_IDLE = 2'b00,
    DSR_COPY = 2'b01,
    DSR_DONE = 2'b11
  } dsr_state_t;

  // Memory request seen by the control path
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        interleaved;
    logic        chan_b;
    logic [2:0]  dimm;
    logic [31:0] addr;
  } dsr_req_t;

  // Routing decision handed back to the control path
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] tgt_dimm;
    logic       dup;
    logic [2:0] dup_dimm;
    logic       use_mirror;
    logic       chunk_swap;
    logic       swap_halves;
  } dsr_route_t;

  // ECC error report
  typedef struct packed {
    logic       valid;
    logic       ded;
    logic [2:0] dimm;
  } dsr_err_t;

endpackage : dsr_pkg

// >>> logic/dsr_ras.sv
// DIMM sparing, memory mirroring and leaky-bucket error-rate logic of the memory controller.
// Assumes synchronous inputs on aclk, an AXI4-Lite master for registers, and a scrub engine
// that pulses scrub_wrap each time it finishes a full pass over memory.
//
// Contract
// [RQ1] Sparing on: one DIMM per channel held in reserve; off: all DIMMs visible.
// [RQ2] After fail-over starts, every write goes to failing DIMM and to spare.
// [RQ3] Track scrub passes; after full coverage spare enters service, failing DIMM offline.
// [RQ4] Only one sparing cycle; no new start after one completes.
// [RQ5] Threshold event escalates as configured: SYSTEM_MANAGEMENT_INTERRUPT, interrupt, or polling only.
// [RQ6] Software picks one victim DIMM then commands the sparing copy.
// [RQ7] Copy done by address aliasing inside control path, no boundary reprogramming.
// [RQ8] Mirroring and sparing exclusive; first chosen stays until power cycle.
// [RQ9] Non-zero SEC or DED threshold enables checking; zero disables it.
// [RQ10] At period end add new errors to residue, halve, keep as residue.
// [RQ11] At period end halve all counters and compare with own thresholds.
// [RQ12] Leak period set in sparing control, smallest 1 us, shared by all DIMMs.
// [RQ13] No compare before first period; never-leak setting raises no event.
// [RQ14] Counter over threshold sets that DIMM's flag bit in one register.
// [RQ15] After flag clear, DIMM rearms only once halved count is at or below threshold.
// [RQ16] Spare inherits the failing DIMM's SEC and DED counters with residue.
// [RQ17] Software clears inherited residue with 1 us period for ten periods.
// [RQ18] Mirrored writes go twice, halves swapped so each channel holds a copy.
// [RQ19] Mirrored: uncorrectable error fetches the other copy instead of failing.
// [RQ20] Mirrored read copy chosen by address bit 15, polarity bit inverts.
// [RQ21] Track primary and mirror roles; reorder chunks for all four read cases.
// [RQ22] Mirrored: errors still logged, escalated and counted per DIMM.
// [RQ23] Error counters saturate rather than wrap.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps

module dsr_ras (
  // Clock, reset, enable
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  // AXI4-Lite write address
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [7:0]         awaddr,
  // AXI4-Lite write data
  input  wire logic               wvalid,
  output logic                    wready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  // AXI4-Lite write response
  output logic                    bvalid,
  input  wire logic               bready,
  output logic [1:0]              bresp,
  // AXI4-Lite read
  input  wire logic               arvalid,
  output logic                    arready,
  input  wire logic [7:0]         araddr,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  // Memory control path
  input  wire dsr_pkg::dsr_req_t  req,
  output dsr_pkg::dsr_route_t     route,
  input  wire logic               rd_ue,
  output logic                    retry_other_copy,
  // ECC errors and scrub progress
  input  wire dsr_pkg::dsr_err_t  err,
  input  wire logic               scrub_wrap,
  // Status and escalation
  output logic [7:0]              dimm_offline,
  output logic [7:0]              threshold_exceeded_flags,
  output logic                    system_management_interrupt,
  output logic                    error_interrupt
);

  // Software-visible state and the per-DIMM rearm bits
  logic [11:0]            sparing_control;
  logic [7:0]             double_error_threshold;
  logic [31:0]            single_error_thresholds;
  logic                   mode_locked;
  dsr_pkg::dsr_state_t    state;
  logic                   pass_seen;
  logic [7:0]             armed;

  // Write channel holding
  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             aw_addr_q;
  logic [31:0]            w_data_q;
  logic [3:0]             w_strb_q;
  logic                   wr_fire;
  logic [31:0]            wmask;

  // Leak timing
  logic [5:0]             unit_cnt;
  logic [23:0]            us_cnt;
  logic [23:0]            us_last;
  logic                   period_tick;

  // Error counters and comparison
  logic [7:0]             sec_cnt [dsr_pkg::NUM_DIMMS];
  logic [7:0]             ded_cnt [dsr_pkg::NUM_DIMMS];
  logic [7:0]             over;
  logic [7:0]             flag_set;
  logic [7:0]             flag_clr;
  logic [2:0]             err_slot;

  // Decoded controls
  logic                   spare_en;
  logic                   mirror_en;
  logic [2:0]             period_code;
  logic [1:0]             esc_mode;
  logic                   mir_pol;
  logic [2:0]             victim;

  assign spare_en    = sparing_control[dsr_pkg::CTL_SPARE_EN];
  assign mirror_en   = sparing_control[dsr_pkg::CTL_MIRROR_EN];
  assign period_code = sparing_control[dsr_pkg::CTL_PERIOD_LO +: 3];
  assign esc_mode    = sparing_control[dsr_pkg::CTL_ESC_LO +: 2];
  assign mir_pol     = sparing_control[dsr_pkg::CTL_MIR_POL];
  assign victim      = sparing_control[dsr_pkg::CTL_VICTIM_LO +: 3];

  // Reserve slot of the channel that holds a DIMM
  function automatic logic [2:0] spare_of(input logic [2:0] d);
    spare_of = {d[2], 2'b11};
  endfunction : spare_of

  // True when d belongs to the victim pair (victim and its partner across channels)
  function automatic logic in_victim_pair(input logic [2:0] d, input logic [2:0] v);
    in_victim_pair = (d[1:0] == v[1:0]);
  endfunction : in_victim_pair

  // Saturating add of one error
  function automatic logic [7:0] sat_inc(input logic [7:0] c, input logic inc);
    sat_inc = (inc && c != 8'hFF) ? c + 8'h01 : c;
  endfunction : sat_inc

  // Register read mux
  function automatic logic [31:0] reg_read(input logic [7:0] a, output logic ok);
    ok = 1'b1;
    reg_read = 32'h0000_0000;
    if (a == dsr_pkg::OFF_SPARING_CONTROL) begin
      reg_read = {20'h00000, 1'b0, sparing_control[10:0]};
    end else if (a == dsr_pkg::OFF_DED_THRESHOLD) begin
      reg_read = {24'h000000, double_error_threshold};
    end else if (a == dsr_pkg::OFF_SEC_THRESHOLDS) begin
      reg_read = single_error_thresholds;
    end else if (a == dsr_pkg::OFF_THR_FLAGS) begin
      reg_read = {24'h000000, threshold_exceeded_flags};
    end else if (a == dsr_pkg::OFF_STATUS) begin
      reg_read = {28'h0000000, pass_seen, mode_locked, state};
    end else begin
      ok = 1'b0;
    end
  endfunction : reg_read

  // Byte-lane mask of the held write
  assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_fire = aw_held && w_held && !bvalid;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      aw_held   <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end else if (!aw_held && !bvalid) begin
        awready <= 1'b1;
      end
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready   <= 1'b0;
      w_held   <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end else if (!w_held && !bvalid) begin
        wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= dsr_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (aw_addr_q <= dsr_pkg::OFF_THR_FLAGS && aw_addr_q[1:0] == 2'b00)
                  ? dsr_pkg::RESP_OKAY : dsr_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel, answered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    logic ok;
    ok = 1'b0;
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= dsr_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= reg_read(araddr, ok);
        rresp   <= ok ? dsr_pkg::RESP_OKAY : dsr_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  // Configuration registers; mode bits lock on the first single choice
  always_ff @(posedge aclk) begin
    logic [31:0] nv;
    nv = (32'(sparing_control) & ~wmask) | (w_data_q & wmask);
    if (!aresetn) begin
      sparing_control         <= dsr_pkg::CTL_RESET;
      double_error_threshold  <= dsr_pkg::THR_RESET;
      single_error_thresholds <= {4{dsr_pkg::THR_RESET}};
      mode_locked             <= 1'b0;
    end else if (ce) begin
      sparing_control[dsr_pkg::CTL_START] <= 1'b0;
      if (wr_fire && aw_addr_q == dsr_pkg::OFF_SPARING_CONTROL) begin
        sparing_control[7:2] <= nv[7:2];
        if (state == dsr_pkg::DSR_IDLE) begin
          sparing_control[10:8] <= nv[10:8]; // RQ4
        end
        sparing_control[dsr_pkg::CTL_START] <= nv[dsr_pkg::CTL_START] && w_strb_q[1];
        if (!mode_locked && (nv[0] ^ nv[1])) begin // RQ8
          sparing_control[1:0] <= nv[1:0];
          mode_locked          <= 1'b1;
        end
      end
      if (wr_fire && aw_addr_q == dsr_pkg::OFF_DED_THRESHOLD && w_strb_q[0]) begin
        double_error_threshold <= w_data_q[7:0];
      end
      if (wr_fire && aw_addr_q == dsr_pkg::OFF_SEC_THRESHOLDS) begin
        single_error_thresholds <= (single_error_thresholds & ~wmask) | (w_data_q & wmask);
      end
    end
  end

  // Sparing sequence: idle, copy while scrub covers memory, done for good
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= dsr_pkg::DSR_IDLE;
      pass_seen <= 1'b0;
    end else if (ce) begin
      case (state)
        dsr_pkg::DSR_IDLE: begin
          if (spare_en && sparing_control[dsr_pkg::CTL_START] && victim[1:0] != 2'b11) begin
            state     <= dsr_pkg::DSR_COPY; // RQ6
            pass_seen <= 1'b0;
          end
        end
        dsr_pkg::DSR_COPY: begin
          if (scrub_wrap && pass_seen) begin
            state <= dsr_pkg::DSR_DONE; // RQ3
          end else if (scrub_wrap) begin
            pass_seen <= 1'b1; // RQ3
          end
        end
        dsr_pkg::DSR_DONE: begin
          state <= dsr_pkg::DSR_DONE; // RQ4
        end
        default: begin
          state <= dsr_pkg::DSR_IDLE;
        end
      endcase
    end
  end

  // Leak period timer: code 0 never leaks, code n lasts 16^(n-1) us
  assign us_last     = 24'((32'h1 << (dsr_pkg::PERIOD_SHIFT * (period_code - 3'd1))) - 32'h1);
  assign period_tick = (period_code != 3'd0) && (unit_cnt == dsr_pkg::UNIT_LAST)
                       && (us_cnt >= us_last); // RQ12 RQ13

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_cnt <= 6'h00;
      us_cnt   <= 24'h000000;
    end else if (ce) begin
      if (period_code == 3'd0) begin
        unit_cnt <= 6'h00;
        us_cnt   <= 24'h000000;
      end else if (unit_cnt == dsr_pkg::UNIT_LAST) begin
        unit_cnt <= 6'h00;
        us_cnt   <= period_tick ? 24'h000000 : us_cnt + 24'h000001;
      end else begin
        unit_cnt <= unit_cnt + 6'h01;
      end
    end
  end

  // Errors from an in-service spare land on the failing DIMM's counters
  assign err_slot = (state == dsr_pkg::DSR_DONE && err.dimm[1:0] == 2'b11)
                    ? {err.dimm[2], victim[1:0]} : err.dimm; // RQ16

  // Per-DIMM leaky buckets
  genvar g;
  generate
    for (g = 0; g < dsr_pkg::NUM_DIMMS; g++) begin : g_bucket
      logic       hit;
      logic [7:0] sec_sum;
      logic [7:0] ded_sum;
      logic [7:0] sec_thr;
      assign hit     = err.valid && err_slot == 3'(g); // RQ22
      assign sec_sum = sat_inc(sec_cnt[g], hit && !err.ded); // RQ23
      assign ded_sum = sat_inc(ded_cnt[g], hit && err.ded); // RQ23
      assign sec_thr = single_error_thresholds[8 * (g % 4) +: 8];
      assign over[g] = ((sec_thr != 8'h00) && ({1'b0, sec_sum[7:1]} > sec_thr))
                       || ((double_error_threshold != 8'h00)
                       && ({1'b0, ded_sum[7:1]} > double_error_threshold)); // RQ9 RQ11
      assign flag_set[g] = period_tick && over[g] && armed[g]; // RQ14
      assign flag_clr[g] = wr_fire && aw_addr_q == dsr_pkg::OFF_THR_FLAGS && w_strb_q[0] && w_data_q[g];

      // Add then halve at each period end; result is the next residue
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sec_cnt[g] <= 8'h00;
          ded_cnt[g] <= 8'h00;
        end else if (ce) begin
          sec_cnt[g] <= period_tick ? {1'b0, sec_sum[7:1]} : sec_sum; // RQ10
          ded_cnt[g] <= period_tick ? {1'b0, ded_sum[7:1]} : ded_sum; // RQ10
        end
      end

      // Flag with set over clear; rearm once the halved count decays
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          threshold_exceeded_flags[g] <= 1'b0;
          armed[g]                    <= 1'b1;
        end else if (ce) begin
          threshold_exceeded_flags[g] <= flag_set[g] | (threshold_exceeded_flags[g] & ~flag_clr[g]); // RQ14
          if (flag_clr[g]) begin
            armed[g] <= 1'b0; // RQ15
          end else if (period_tick && !over[g]) begin
            armed[g] <= 1'b1; // RQ15
          end
        end
      end
    end
  endgenerate

  // Escalation of a new threshold event in every sparing state, as esc_mode selects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_management_interrupt <= 1'b0;
      error_interrupt             <= 1'b0;
    end else if (ce) begin
      system_management_interrupt <= (|(flag_set & ~threshold_exceeded_flags)) && esc_mode == dsr_pkg::ESC_SMI; // RQ5
      error_interrupt             <= (|(flag_set & ~threshold_exceeded_flags)) && esc_mode == dsr_pkg::ESC_INT; // RQ5
    end
  end

  // Reserve slots out of service until done, then the victim pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dimm_offline <= 8'h00;
    end else if (ce) begin
      if (!spare_en) begin
        dimm_offline <= 8'h00; // RQ1
      end else if (state == dsr_pkg::DSR_DONE) begin
        dimm_offline <= 8'h11 << victim[1:0]; // RQ3
      end else begin
        dimm_offline <= 8'h88; // RQ1
      end
    end
  end

  // Request routing: aliasing for sparing, copy selection for mirroring
  always_ff @(posedge aclk) begin
    logic use_m;
    use_m = req.addr[dsr_pkg::MIRROR_ADDR_BIT] ^ mir_pol; // RQ20
    if (!aresetn) begin
      route            <= '0;
      retry_other_copy <= 1'b0;
    end else if (ce) begin
      route.valid       <= req.valid;
      route.write       <= req.write;
      route.tgt_dimm    <= req.dimm;
      route.dup         <= 1'b0;
      route.dup_dimm    <= spare_of(req.dimm);
      route.use_mirror  <= 1'b0;
      route.chunk_swap  <= 1'b0;
      route.swap_halves <= 1'b0;
      if (spare_en && state == dsr_pkg::DSR_COPY && in_victim_pair(req.dimm, victim)) begin
        route.dup <= req.valid && req.write; // RQ2 RQ7
      end
      if (spare_en && state == dsr_pkg::DSR_DONE && in_victim_pair(req.dimm, victim)) begin
        route.tgt_dimm <= spare_of(req.dimm); // RQ7
      end
      if (mirror_en) begin
        route.dup         <= req.valid && req.write; // RQ18
        route.dup_dimm    <= req.dimm ^ 3'b100;
        route.swap_halves <= req.valid && req.write; // RQ18
        route.use_mirror  <= !req.write && use_m; // RQ20 RQ21
        route.chunk_swap  <= !req.write && (req.interleaved ? use_m : req.chan_b); // RQ21
      end
      retry_other_copy <= mirror_en && rd_ue; // RQ19
    end
  end

endmodule : dsr_ras

// >>> bench/dsr_ras_sva.sv
// Checker for the sparing, mirroring and error-rate block.
// Sees only top-level ports; bound from the testbench top.
`timescale 1ns/1ps
module dsr_ras_sva (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Memory path
  input wire dsr_pkg::dsr_req_t   req,
  input wire dsr_pkg::dsr_route_t route,
  input wire logic                rd_ue,
  input wire logic                retry_other_copy,
  // Status and escalation
  input wire logic [7:0]          dimm_offline,
  input wire logic [7:0]          threshold_exceeded_flags,
  input wire logic                system_management_interrupt,
  input wire logic                error_interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write request offered to the control path
  sequence s_wr_req;
    req.valid && req.write;
  endsequence
  // Routing follows requests by one cycle
  a_route_track: assert property (route.valid == $past(req.valid))
    else $error("route not one cycle after request");
  a_mirror_dup: assert property (s_wr_req ##1 route.swap_halves |->
    route.dup && route.dup_dimm == ($past(req.dimm) ^ 3'h4)) else $error("mirror copy not duplicated");
  a_chunk_swap: assert property (route.use_mirror && $past(req.interleaved) |-> route.chunk_swap)
    else $error("interleaved mirror read not reordered");
  a_retry_cause: assert property (retry_other_copy |-> $past(rd_ue))
    else $error("retry without uncorrectable error");
  // Escalation only with a newly set flag
  a_esc_flag: assert property (system_management_interrupt || error_interrupt |->
    (threshold_exceeded_flags & ~$past(threshold_exceeded_flags)) != 8'h00) else $error("escalation without flag");
  a_esc_one: assert property (!(system_management_interrupt && error_interrupt))
    else $error("two escalations at once");
  // Offline patterns and their permanence
  a_offline_set: assert property (dimm_offline != 8'h00 |->
    dimm_offline inside {8'h88, 8'h11, 8'h22, 8'h44}) else $error("bad offline pattern");
  a_offline_keep: assert property ($past(dimm_offline) inside {8'h11, 8'h22, 8'h44} |->
    $stable(dimm_offline)) else $error("completed sparing undone");
endmodule : dsr_ras_sva

// >>> bench/dsr_dimm_model.sv
// Behavioural DIMMs on both channels.
// Reports an ECC error a cycle after each read routed to a DIMM marked faulty.
`timescale 1ns/1ps
module dsr_dimm_model (
  // Clock
  input  wire logic                aclk,
  // Routed traffic and fault marks
  input  wire dsr_pkg::dsr_route_t route,
  input  wire logic [7:0]          sec_mask,
  input  wire logic [7:0]          ded_mask,
  input  wire logic [7:0]          ue_mask,
  // Reports back to the controller
  output dsr_pkg::dsr_err_t        err = '0,
  output logic                     rd_ue = 1'b0
);
  logic rd;
  assign rd = route.valid && !route.write;
  // One report per faulty read
  always @(posedge aclk) begin
    err.valid <= rd && (sec_mask[route.tgt_dimm] || ded_mask[route.tgt_dimm]);
    err.ded <= ded_mask[route.tgt_dimm];
    err.dimm <= route.tgt_dimm;
    rd_ue <= rd && ue_mask[route.tgt_dimm];
  end
endmodule : dsr_dimm_model

// >>> bench/testbench.sv
// Self-checking bench for the sparing, mirroring and error-rate block.
// Registers over AXI4-Lite; memory traffic answered by the DIMM model.
`timescale 1ns/1ps
module testbench;
  logic                aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic                rvalid, rready, rd_ue, retry_other_copy, scrub_wrap, system_management_interrupt;
  logic                error_interrupt;
  logic [7:0]          awaddr, araddr, dimm_offline, threshold_exceeded_flags, sec_mask, ded_mask, ue_mask;
  logic [31:0]         wdata, rdata;
  logic [1:0]          bresp, rresp;
  dsr_pkg::dsr_req_t   req;
  dsr_pkg::dsr_route_t route, rq;
  dsr_pkg::dsr_err_t   err;
  int                  err_count, n_checks, n_int, n_smi, n_retry;
  dsr_ras dut_u (.ce(1'b1), .wstrb(4'hF), .*);
  dsr_dimm_model dimm_u (.*);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Pulse counters
  always @(posedge aclk) begin
    n_int += (error_interrupt === 1'b1);
    n_smi += (system_management_interrupt === 1'b1);
    n_retry += (retry_other_copy === 1'b1);
  end
  // Watchdog
  initial begin
    #400000;
    err_count++;
    end_of_test();
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rst();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  // Register write: address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = dsr_pkg::RESP_OKAY);
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1;
        bready <= 1'b0;
        chk("bresp", er, bresp);
      end
    end
  endtask : wr
  // Register read with masked compare
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er = dsr_pkg::RESP_OKAY);
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1;
        rready <= 1'b0;
        chk($sformatf("reg %h", a), e, rdata & m);
        chk("rresp", er, rresp);
      end
    end
  endtask : rc
  // One memory request, routing captured a cycle later
  task automatic rt(input logic w, il, cb, input logic [2:0] dm, input logic a15);
    @(posedge aclk);
    req <= '{1'b1, w, il, cb, dm, {16'h0, a15, 15'h0}};
    @(posedge aclk);
    req <= '0;
    #1 rq = route;
  endtask : rt
  task automatic wt(input logic [7:0] f);
    for (int t = 0; t < 300 && threshold_exceeded_flags !== f; t++)
      @(posedge aclk);
  endtask : wt
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, scrub_wrap, awaddr, araddr, wdata} = '0;
    {sec_mask, ded_mask, ue_mask, req} = '0;
    rst();
    // Reset values and refused accesses
    for (int i = 0; i < 5; i++)
      rc(8'(4 * i), '1, 32'h0);
    rc(8'h14, '1, 32'h0, dsr_pkg::RESP_SLVERR);
    wr(8'h10, 32'h1, dsr_pkg::RESP_SLVERR);
    // Never-leak period: errors pile up unflagged
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h21);
    ded_mask <= 8'h02;
    sec_mask <= 8'h04;
    repeat (10) rt(0, 0, 0, 3'd1, 0);
    repeat (10) rt(0, 0, 0, 3'd2, 0);
    repeat (200) @(posedge aclk);
    chk("flags", 8'h00, threshold_exceeded_flags);
    // 1 us leak: halved residue crosses, zero SEC threshold stays quiet
    wr(8'h00, 32'h25);
    wt(8'h02);
    rc(8'h0C, '1, 32'h2);
    chk("int count", 1, n_int);
    // Cleared while still over: disarmed until decay, then rearmed
    repeat (40) rt(0, 0, 0, 3'd1, 0);
    wr(8'h0C, 32'h2);
    repeat (45) @(posedge aclk);
    rc(8'h0C, '1, 32'h0);
    wr(8'h00, 32'h05);
    repeat (400) @(posedge aclk);
    repeat (20) rt(0, 0, 0, 3'd1, 0);
    wt(8'h02);
    rc(8'h0C, '1, 32'h2);
    chk("int count", 1, n_int);
    // Sparing of DIMM 1: writes duplicated to its channel's spare
    wr(8'h00, 32'h905);
    rc(8'h10, 32'h3, 32'h1);
    chk("offline", 8'h88, dimm_offline);
    rt(1, 0, 0, 3'd1, 0);
    chk("dup", 4'hB, {rq.dup, rq.dup_dimm});
    rt(1, 0, 0, 3'd5, 0);
    chk("dup", 4'hF, {rq.dup, rq.dup_dimm});
    rt(1, 0, 0, 3'd0, 0);
    chk("dup", 1'b0, rq.dup);
    for (int i = 1; i <= 2; i++) begin
      @(posedge aclk);
      scrub_wrap <= 1'b1;
      @(posedge aclk);
      scrub_wrap <= 1'b0;
      rc(8'h10, i == 1 ? 32'hB : 32'h3, i == 1 ? 32'h9 : 32'h3);
    end
    chk("offline", 8'h22, dimm_offline);
    rt(1, 0, 0, 3'd1, 0);
    chk("alias", 3'd3, rq.tgt_dimm);
    // Spare inherits the victim's counters; no second cycle
    ded_mask <= 8'h08;
    wr(8'h0C, 32'h2);
    repeat (500) @(posedge aclk);
    repeat (20) rt(0, 0, 0, 3'd1, 0);
    wt(8'h02);
    rc(8'h0C, '1, 32'h2);
    wr(8'h00, 32'hA05);
    rc(8'h10, 32'h3, 32'h3);
    chk("offline", 8'h22, dimm_offline);
    // Mirrored mode after a fresh reset, both read polarities
    rst();
    wr(8'h04, 32'h2);
    for (int p = 0; p < 2; p++) begin
      wr(8'h00, 32'h46 | (p << 7));
      rt(1, 0, 0, 3'd1, 0);
      chk("mirror wr", 5'h1B, {rq.dup, rq.dup_dimm, rq.swap_halves});
      for (int i = 0; i < 8; i++) begin
        rt(0, i[2], i[1], 3'd1, i[0]);
        chk("copy", {i[0] ^ p[0], i[2] ? i[0] ^ p[0] : i[1]}, {rq.use_mirror, rq.chunk_swap});
      end
    end
    wr(8'h00, 32'hC5);
    rc(8'h00, 32'h3, 32'h2);
    ue_mask <= 8'h22;
    rt(0, 0, 0, 3'd1, 0);
    repeat (4) @(posedge aclk);
    chk("retry", 1, n_retry);
    ded_mask <= 8'h22;
    repeat (20) rt(0, 0, 0, 3'd1, 0);
    repeat (150) @(posedge aclk);
    chk("flags set", 1, threshold_exceeded_flags != 8'h00);
    chk("smi", 1, n_smi != 0);
    end_of_test();
  end
endmodule : testbench
bind dsr_ras dsr_ras_sva chk_u (.*);
